// File: hw/drive_out_pkg.sv
// Constants for the drive status and meter output block.
// Operation
// - Function 01 drives output active while speed has reached the setpoint.
// - Function 02 drives output active while speed exceeds both window thresholds.
// - Function 00 drives output active while the motor is running.
// - Function 03 drives output active while load exceeds the warning level.
// - Function 04 drives output active while PID error exceeds its limit.
// - Function 05 drives output active while a drive fault is present.
// - With relay function 05, without fault the relay joins common to the ok contact.
// - On fault (relay function 05) or power loss relay falls to common-trip, de-energised.
// - Meter source 00 speed PWM, 01 current PWM, 02 pulse train.
// - In current mode rated current gives half of full scale.
// - In PWM modes the meter period stays constant.
// - PWM high time is proportional to value, zero to maximum speed.
// - Trim 0 to 255, default 80, scales both PWM modes live.
// - Trim has no effect on the pulse train.
// - Pulse train toggles at speed-proportional rate with about 50 % duty.
// - Pulse rate is 100 times output speed times the rate factor.
// - Factor 0.1 to 99.9, default 1.0; product reported as scaled speed.
package drive_out_pkg;
  localparam logic [2:0] FN_RUN = 3'h0;
  localparam logic [2:0] FN_AT_TARGET = 3'h1;
  localparam logic [2:0] FN_ABOVE_WINDOW = 3'h2;
  localparam logic [2:0] FN_OVERLOAD = 3'h3;
  localparam logic [2:0] FN_PID_ERROR = 3'h4;
  localparam logic [2:0] FN_FAULT = 3'h5;
  localparam logic [1:0] METER_SPEED_PWM = 2'h0;
  localparam logic [1:0] METER_CURRENT_PWM = 2'h1;
  localparam logic [1:0] METER_PULSES = 2'h2;
  localparam logic [7:0] TRIM_DEFAULT = 8'h50;
  localparam logic [7:0] TRIM_UNITY = 8'h80;
  localparam logic [9:0] FACTOR_MIN = 10'h001;
  localparam logic [9:0] FACTOR_MAX = 10'h3E7;
  localparam logic [9:0] FACTOR_DEFAULT = 10'h00A;
  localparam logic [9:0] FACTOR_DIV = 10'h00A;
  localparam int PWM_PERIOD_US = 1000;
  localparam int CLOCK_MHZ = 200;
  localparam int PWM_PERIOD_CYCLES = PWM_PERIOD_US * CLOCK_MHZ;
  localparam int CLOCKS_PER_HZ_TENTH = CLOCK_MHZ * 1000000 / 20;
endpackage : drive_out_pkg

// File: hw/drive_status_and_meter_outputs.sv
// Status routing, fault relay and meter pin generator of the drive.
`timescale 1ns/10ps
`default_nettype none
module drive_status_and_meter_outputs
  import drive_out_pkg::*;
#(
  parameter int SPEED_W = 16,
  parameter int PWM_PERIOD = PWM_PERIOD_CYCLES,
  parameter int PULSE_ACC_MOD = CLOCKS_PER_HZ_TENTH
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Drive state, same clock domain, speed in 0.1 Hz.
  input wire logic motor_running,
  input wire logic drive_fault,
  input wire logic [SPEED_W-1:0] output_speed_monitor,
  input wire logic [SPEED_W-1:0] speed_setpoint,
  input wire logic [SPEED_W-1:0] max_speed,
  input wire logic [15:0] load_level,
  input wire logic [15:0] rated_current,
  input wire logic [15:0] pid_error,
  // Configuration.
  input wire logic [2:0] output_one_function_sel,
  input wire logic [2:0] output_two_function_sel,
  input wire logic [2:0] relay_function_sel,
  input wire logic [1:0] meter_source_sel,
  input wire logic [15:0] overcurrent_warn_level,
  input wire logic [SPEED_W-1:0] speed_up_threshold,
  input wire logic [SPEED_W-1:0] speed_down_threshold,
  input wire logic [15:0] pid_error_limit,
  input wire logic [7:0] meter_pwm_trim,
  input wire logic [9:0] pulse_rate_factor,
  // Status outputs.
  output logic digital_out_one,
  output logic digital_out_two,
  output logic relay_energise,
  output logic speed_target_reached_flag,
  output logic speed_above_window_flag,
  output logic overcurrent_warning_flag,
  output logic pid_error_exceed_flag,
  output logic trip_fault_flag,
  // Meter pin and scaled speed monitor.
  output logic meter_pulse_pin,
  output logic [SPEED_W+9:0] scaled_speed_monitor
);

  localparam int PW = $clog2(PWM_PERIOD + 1);
  localparam int AW = $clog2(PULSE_ACC_MOD + 1) + 1;
  localparam logic [PW-1:0] PERIOD_LAST = PW'(PWM_PERIOD - 1);
  localparam logic [AW-1:0] ACC_MOD = AW'(PULSE_ACC_MOD);

  // Selects one status condition by function code.
  function automatic logic pick(input logic [2:0] code, input logic [5:0] c);
    logic r;
    r = 1'b0;
    unique case (code)
      FN_RUN: r = c[0];
      FN_AT_TARGET: r = c[1];
      FN_ABOVE_WINDOW: r = c[2];
      FN_OVERLOAD: r = c[3];
      FN_PID_ERROR: r = c[4];
      FN_FAULT: r = c[5];
      default: r = 1'b0;
    endcase
    return r;
  endfunction : pick

  wire logic at_target = output_speed_monitor >= speed_setpoint;
  wire logic above_window = (output_speed_monitor > speed_up_threshold) &&
    (output_speed_monitor > speed_down_threshold);
  wire logic overload = load_level > overcurrent_warn_level;
  wire logic pid_over = pid_error > pid_error_limit;
  wire logic [5:0] conds = {drive_fault, pid_over, overload, above_window,
    at_target, motor_running};

  // With function 05 the relay is energised only when healthy, so losing supply trips it; other codes energise it on their condition.
  wire logic relay_fault = (relay_function_sel == FN_FAULT) ? drive_fault :
    ~pick(relay_function_sel, conds);
  wire logic next_relay = ~relay_fault;

  // Factor is clamped into its legal range; the value is in tenths.
  wire logic [9:0] factor = (pulse_rate_factor < FACTOR_MIN) ? FACTOR_MIN :
    (pulse_rate_factor > FACTOR_MAX) ? FACTOR_MAX : pulse_rate_factor;
  wire logic [SPEED_W+9:0] next_scaled =
    ((SPEED_W+10)'(output_speed_monitor) * (SPEED_W+10)'(factor)) /
    (SPEED_W+10)'(FACTOR_DIV);

  // Duty fraction in 16 bits, then trimmed; trim 128 is unity gain.
  wire logic [31:0] speed_frac = (max_speed == '0) ? 32'h0 :
    ((32'(output_speed_monitor) << 16) / 32'(max_speed));
  wire logic [31:0] current_frac = (rated_current == 16'h0) ? 32'h0 :
    ((32'(load_level) << 15) / 32'(rated_current));
  wire logic [31:0] raw_frac = (meter_source_sel == METER_CURRENT_PWM) ?
    current_frac : speed_frac;
  wire logic [39:0] trimmed = (40'(raw_frac) * 40'(meter_pwm_trim)) /
    40'(TRIM_UNITY);
  wire logic [15:0] duty_frac = (trimmed > 40'h0FFFF) ? 16'hFFFF :
    trimmed[15:0];
  wire logic [PW+15:0] high_wide = (PW+16)'(duty_frac) * (PW+16)'(PWM_PERIOD);
  wire logic [PW-1:0] high_time = high_wide[PW+15:16];

  logic [PW-1:0] pwm_count;
  logic [AW-1:0] pulse_acc;
  wire logic pwm_end = pwm_count == PERIOD_LAST;
  wire logic next_pwm = pwm_count < high_time;

  // Phase accumulator: scaled speed in tenths of Hz per clock, wraps twice
  // per output cycle so each half period is equal. Untrimmed by design.
  wire logic [AW:0] acc_sum = (AW+1)'(pulse_acc) +
    (AW+1)'(scaled_speed_monitor);
  wire logic acc_wrap = acc_sum >= (AW+1)'(ACC_MOD);
  wire logic [AW:0] acc_less = acc_sum - (AW+1)'(ACC_MOD);
  wire logic [AW-1:0] next_acc = acc_wrap ? acc_less[AW-1:0] :
    acc_sum[AW-1:0];
  logic pulse_level;
  wire logic next_meter = (meter_source_sel == METER_PULSES) ? pulse_level :
    (meter_source_sel == METER_SPEED_PWM ||
     meter_source_sel == METER_CURRENT_PWM) ? next_pwm : 1'b0;

  always_ff @(posedge clock) begin
    if (rst) begin
      pwm_count <= '0;
      pulse_acc <= '0;
      pulse_level <= 1'b0;
    end else begin
      pwm_count <= pwm_end ? '0 : pwm_count + 1'b1;
      pulse_acc <= next_acc;
      if (acc_wrap) begin
        pulse_level <= ~pulse_level;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      digital_out_one <= 1'b0;
      digital_out_two <= 1'b0;
      relay_energise <= 1'b0;
      speed_target_reached_flag <= 1'b0;
      speed_above_window_flag <= 1'b0;
      overcurrent_warning_flag <= 1'b0;
      pid_error_exceed_flag <= 1'b0;
      trip_fault_flag <= 1'b0;
      meter_pulse_pin <= 1'b0;
      scaled_speed_monitor <= '0;
    end else begin
      digital_out_one <= pick(output_one_function_sel, conds);
      digital_out_two <= pick(output_two_function_sel, conds);
      relay_energise <= next_relay;
      speed_target_reached_flag <= at_target;
      speed_above_window_flag <= above_window;
      overcurrent_warning_flag <= overload;
      pid_error_exceed_flag <= pid_over;
      trip_fault_flag <= drive_fault;
      meter_pulse_pin <= next_meter;
      scaled_speed_monitor <= next_scaled;
    end
  end

endmodule : drive_status_and_meter_outputs
`default_nettype wire

// File: sim/meter_probe.sv
// Meter model that times the high phase of the meter pin.
`timescale 1ns/10ps
`default_nettype none
module meter_probe (
  // Clock and the pin being measured.
  input wire logic clock,
  input wire logic rst,
  input wire logic meter_pulse_pin,
  // Length of the last finished high phase, in clocks.
  output logic [31:0] high_time
);
  logic [31:0] hi_run;
  logic last;
  always_ff @(posedge clock) begin
    if (rst) begin
      last <= 1'b0;
      hi_run <= '0;
      high_time <= '0;
    end else begin
      last <= meter_pulse_pin;
      hi_run <= meter_pulse_pin ? hi_run + 1 : '0;
      if (last && !meter_pulse_pin) begin
        high_time <= hi_run;
      end
    end
  end
endmodule : meter_probe
`default_nettype wire

// File: sim/drive_outputs_monitor.sv
// Port checker for the drive status outputs.
`timescale 1ns/10ps
`default_nettype none
module drive_outputs_monitor
  import drive_out_pkg::*;
(
  // Watched ports.
  input wire logic clock, rst, motor_running, drive_fault,
  input wire logic [15:0] load_level, overcurrent_warn_level,
  input wire logic [15:0] pid_error, pid_error_limit,
  input wire logic [2:0] output_one_function_sel, relay_function_sel,
  input wire logic digital_out_one, relay_energise, trip_fault_flag,
  input wire logic overcurrent_warning_flag, pid_error_exceed_flag
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_fault_flag: assert property (
    drive_fault |=> trip_fault_flag) else $error("fault flag");
  chk_run_out: assert property (
    output_one_function_sel == FN_RUN |-> ##1
    digital_out_one == $past(motor_running)) else $error("run out");
  chk_fault_out: assert property (
    output_one_function_sel == FN_FAULT && drive_fault |=> digital_out_one)
    else $error("fault out");
  chk_relay_ok: assert property (
    relay_function_sel == FN_FAULT && !drive_fault |=> relay_energise)
    else $error("relay dropped");
  chk_relay_trip: assert property (
    relay_function_sel == FN_FAULT && drive_fault |=> !relay_energise)
    else $error("relay held");
  chk_overload_cause: assert property (
    overcurrent_warning_flag |->
    $past(load_level) > $past(overcurrent_warn_level)) else $error("load");
  chk_pid_flag: assert property (
    (pid_error > pid_error_limit) [*2] |-> pid_error_exceed_flag)
    else $error("pid flag");
  chk_pid_clear: assert property (
    pid_error <= pid_error_limit |=> !pid_error_exceed_flag)
    else $error("pid clear");
  cover property (drive_fault ##1 !relay_energise);
  cover property (overcurrent_warning_flag);
  cover property (digital_out_one && output_one_function_sel == FN_RUN);
endmodule : drive_outputs_monitor
bind drive_status_and_meter_outputs drive_outputs_monitor monitor_i (.*);
`default_nettype wire

// File: sim/testbench.sv
// Bench for the drive status and meter output block.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import drive_out_pkg::*;
  typedef struct {int k; logic [31:0] v;} note_t;
  logic clock = 1'b0, rst = 1'b1, motor_running, drive_fault;
  logic [15:0] output_speed_monitor, speed_setpoint, load_level, pid_error;
  logic [15:0] speed_up_threshold, speed_down_threshold, pid_error_limit;
  logic [15:0] overcurrent_warn_level, max_speed = 16'h3E8;
  logic [15:0] rated_current = 16'h3E8;
  logic [2:0] output_one_function_sel, output_two_function_sel;
  logic [2:0] relay_function_sel;
  logic [1:0] meter_source_sel = 2'h0;
  logic [7:0] meter_pwm_trim = TRIM_DEFAULT;
  logic [9:0] pulse_rate_factor = FACTOR_DEFAULT;
  logic digital_out_one, digital_out_two, relay_energise, meter_pulse_pin;
  logic speed_target_reached_flag, speed_above_window_flag;
  logic overcurrent_warning_flag, pid_error_exceed_flag, trip_fault_flag;
  logic [25:0] scaled_speed_monitor;
  logic [31:0] high_time;
  note_t notes[$];
  int mismatches = 0, checked = 0;
  event look;
  // Mode, trim, speed, factor, output, expected.
  int tab[9][6] = '{'{0, 128, 500, 10, 3, 50}, '{0, 64, 500, 10, 3, 25},
    '{0, 80, 500, 10, 3, 31}, '{1, 128, 500, 10, 3, 50},
    '{2, 0, 100, 10, 3, 10}, '{2, 128, 100, 25, 3, 4},
    '{2, 128, 100, 25, 4, 250}, '{2, 9, 100, 1000, 4, 9990},
    '{2, 9, 100, 0, 4, 10}};
  drive_status_and_meter_outputs #(.PWM_PERIOD(100), .PULSE_ACC_MOD(1000))
    drive_status_and_meter_outputs_i (.*);
  meter_probe meter_probe_i (.*);
  always #2.5 clock = ~clock;
  function automatic logic [31:0] pick(int k);
    logic [31:0] o[7];
    o = '{digital_out_one, digital_out_two, relay_energise, high_time,
      scaled_speed_monitor, speed_target_reached_flag,
      speed_above_window_flag};
    return o[k];
  endfunction : pick
  task automatic want(int k, logic [31:0] v);
    notes.push_back('{k, v});
    -> look;
  endtask : want
  task automatic close_out;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  task automatic settle(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : settle
  initial begin
    note_t n;
    forever begin
      @(look);
      while (notes.size() > 0) begin
        n = notes.pop_front();
        checked++;
        if (pick(n.k) !== n.v) begin
          mismatches++;
          $display("unexpected output %0d exp %0h got %0h", n.k, n.v,
            pick(n.k));
        end
      end
    end
  end
  initial begin
    settle(9000);
    mismatches++;
    close_out;
  end
  initial begin
    logic [7:0] c;
    void'($urandom(13));
    for (int i = 0; i < 33; i++) begin
      {motor_running, drive_fault} <= 2'($urandom);
      {output_speed_monitor, speed_setpoint} <= $urandom;
      {speed_up_threshold, speed_down_threshold} <= $urandom;
      {load_level, overcurrent_warn_level} <= $urandom;
      {pid_error, pid_error_limit} <= $urandom;
      output_one_function_sel <= 3'(i % 8);
      output_two_function_sel <= 3'(7 - i % 8);
      relay_function_sel <= 3'(i % 8);
      settle(i == 0 ? 16 : 2);
      rst <= 1'b0;
      c = {2'h0, drive_fault, pid_error > pid_error_limit,
        load_level > overcurrent_warn_level,
        output_speed_monitor > speed_up_threshold &&
        output_speed_monitor > speed_down_threshold,
        output_speed_monitor >= speed_setpoint, motor_running};
      if (i > 0) want(0, c[i % 8]);
      if (i > 0) want(1, c[7 - i % 8]);
      if (i > 0) want(2, i % 8 == 5 ? !drive_fault : c[i % 8]);
      if (i > 0) want(5, c[1]);
      if (i > 0) want(6, c[2]);
      @(posedge clock);
    end
    $display("status routing done");
    rst <= 1'b1;
    drive_fault <= 1'b0;
    relay_function_sel <= FN_FAULT;
    settle(2);
    want(2, 0);
    rst <= 1'b0;
    settle(2);
    want(2, 1);
    for (int i = 0; i < 9; i++) begin
      meter_source_sel <= 2'(tab[i][0]);
      meter_pwm_trim <= 8'(tab[i][1]);
      output_speed_monitor <= 16'(tab[i][2]);
      pulse_rate_factor <= 10'(tab[i][3]);
      load_level <= 16'h3E8;
      settle(300);
      want(tab[i][4], tab[i][5]);
    end
    $display("meter done");
    close_out;
  end
endmodule : testbench
`default_nettype wire
